// >>> shared/dct_pkg.sv
// constants, types and register map of the debug compare and trace registers
// Behaviour
// - user force-reset writes ignored; reads return zero
// - host serial write of bit 0 resets processor
// - four comparator bytes, cleared by reset
// - comparator bytes readable; writable only while disarmed
// - fifo high port read-only; zero in event-only
// - fifo high read never advances the fifo
// - fifo low read advances; writes do nothing
// - event-only modes store bytes in low half
// - fifo low reads do not advance while armed
// - disarmed low read stores last fetch address
// - profiled value reappears on the ninth read
// - nine bytes of normally mapped register space
// - enable cannot be set while secured
// - arm sets flag; run end or clear stops
// - bit 5 picks force or tag breaks
// - end trace breaks at trigger, begin when full
// - break enable low stores but never breaks
// - comparator A direction qualifier bits 3 and 2
// - comparator B direction qualifier bits 1 and 0
// - control register accessible at any time
// - run ends when full or on trigger
// - mode 0011 is event-only comparator B
package dct_pkg;
  // ==========================================
  // register offsets
  localparam logic [3:0] OFS_CMP_A_HIGH = 4'h0;
  localparam logic [3:0] OFS_CMP_A_LOW  = 4'h1;
  localparam logic [3:0] OFS_CMP_B_HIGH = 4'h2;
  localparam logic [3:0] OFS_CMP_B_LOW  = 4'h3;
  localparam logic [3:0] OFS_FIFO_HIGH  = 4'h4;
  localparam logic [3:0] OFS_FIFO_LOW   = 4'h5;
  localparam logic [3:0] OFS_CONTROL    = 4'h6;
  localparam logic [3:0] OFS_FORCE_RST  = 4'h9;
  // ==========================================
  // control register fields
  localparam int CTL_ENABLE  = 7;
  localparam int CTL_ARM     = 6;
  localparam int CTL_TAG     = 5;
  localparam int CTL_BRK_EN  = 4;
  localparam int CTL_A_DIR   = 3;
  localparam int CTL_A_DIREN = 2;
  localparam int CTL_B_DIR   = 1;
  localparam int CTL_B_DIREN = 0;
  localparam int FRC_BIT     = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ==========================================
  // fifo geometry
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  // ==========================================
  // trigger mode codes
  localparam logic [3:0] TRG_A_ONLY     = 4'h0;
  localparam logic [3:0] TRG_A_OR_B     = 4'h1;
  localparam logic [3:0] TRG_A_THEN_B   = 4'h2;
  localparam logic [3:0] TRG_EVENT_B    = 4'h3;
  localparam logic [3:0] TRG_A_THEN_EVB = 4'h4;
  localparam logic [3:0] TRG_A_AND_B    = 4'h5;
  localparam logic [3:0] TRG_A_NOT_B    = 4'h6;
  localparam logic [3:0] TRG_INSIDE     = 4'h7;
  localparam logic [3:0] TRG_OUTSIDE    = 4'h8;
  // ==========================================
  // run sequencer states
  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_WAIT,
    RUN_STORE
  } dct_run_type;
endpackage : dct_pkg

// >>> design/dct_cmp.sv
// one address comparator with optional bus direction qualifier
`timescale 1ns/1ps
module dct_cmp (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // setup
  input  wire logic [15:0] cmp_value,
  input  wire logic        dir_enable,
  input  wire logic        dir_select,
  // watched bus
  input  wire logic        bus_valid,
  input  wire logic        bus_rnw,
  input  wire logic [15:0] bus_addr,
  // result
  output logic             match
);
  typedef struct packed {
    logic match;
  } dct_cmp_st_type;

  dct_cmp_st_type st_q;
  dct_cmp_st_type st_d;

  // ==========================================
  // compare; direction only counts when qualified (1 = reads only)
  always_comb begin
    st_d = st_q;
    st_d.match = bus_valid && (bus_addr == cmp_value)
                 && (!dir_enable || (bus_rnw == dir_select));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign match = st_q.match;
endmodule : dct_cmp

// >>> design/dct_mem.sv
// eight-word trace store with registered, write-through read data
`timescale 1ns/1ps
module dct_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // write port
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  // read port
  input  wire logic [2:0]  rd_addr,
  output logic [15:0]      rd_data
);
  typedef struct packed {
    logic [7:0][15:0] words;
    logic [15:0]      rdata;
  } dct_mem_st_type;

  dct_mem_st_type st_q;
  dct_mem_st_type st_d;

  // ==========================================
  // bypass keeps the head word current when it is written this cycle
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.words[wr_addr] = wr_data;
    end
    st_d.rdata = st_d.words[rd_addr];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rdata;
endmodule : dct_mem

// >>> design/dct_top.sv
// debug comparators, trace fifo ports and control register
`timescale 1ns/1ps
module dct_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // processor register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_bdm,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // settings held by neighbouring blocks
  input  wire logic        secure,
  input  wire logic [3:0]  trig_mode,
  input  wire logic        trig_begin,
  // watched processor bus
  input  wire logic        bus_valid,
  input  wire logic        bus_rnw,
  input  wire logic        bus_fetch,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_data,
  // requests and status
  output logic             break_req,
  output logic             break_tag,
  output logic             force_reset,
  output logic             run_active_flag,
  output logic [3:0]       fifo_count
);
  import dct_pkg::*;

  typedef struct packed {
    logic [7:0]  cah;
    logic [7:0]  cal;
    logic [7:0]  cbh;
    logic [7:0]  cbl;
    logic [7:0]  ctl;
    logic [2:0]  wp;
    logic [2:0]  rp;
    logic [3:0]  cnt;
    dct_run_type run;
    logic        a_seen;
    logic        valid;
    logic        fetch;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [15:0] last_fetch;
    logic        brk;
    logic        brk_tag;
    logic        frc;
    logic [7:0]  rdata;
  } dct_top_st_type;

  dct_top_st_type st_q;
  dct_top_st_type st_d;

  logic        match_a;
  logic        match_b;
  logic [15:0] head;
  logic        mem_we;
  logic [2:0]  mem_wa;
  logic [15:0] mem_wd;
  logic        armed;
  logic        event_only;
  logic        begin_eff;
  logic        trig;
  logic        done;
  logic        arm_new;
  logic        en_new;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;

  assign cmp_a      = {st_q.cah, st_q.cal};
  assign cmp_b      = {st_q.cbh, st_q.cbl};
  assign armed      = st_q.ctl[CTL_ENABLE] && st_q.ctl[CTL_ARM];
  assign event_only = (trig_mode == TRG_EVENT_B) || (trig_mode == TRG_A_THEN_EVB);
  // event-only runs are always begin traces
  assign begin_eff  = event_only || trig_begin;

  // ==========================================
  // comparators
  dct_cmp u_cmp_a (
    .clk        (clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .cmp_value  (cmp_a),
    .dir_enable (st_q.ctl[CTL_A_DIREN]),
    .dir_select (st_q.ctl[CTL_A_DIR]),
    .bus_valid  (bus_valid),
    .bus_rnw    (bus_rnw),
    .bus_addr   (bus_addr),
    .match      (match_a)
  );

  dct_cmp u_cmp_b (
    .clk        (clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .cmp_value  (cmp_b),
    .dir_enable (st_q.ctl[CTL_B_DIREN]),
    .dir_select (st_q.ctl[CTL_B_DIR]),
    .bus_valid  (bus_valid),
    .bus_rnw    (bus_rnw),
    .bus_addr   (bus_addr),
    .match      (match_b)
  );

  // ==========================================
  // trace store
  dct_mem u_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (st_d.rp),
    .rd_data (head)
  );

  // ==========================================
  // trigger decode; matches and sampled bus are aligned one cycle late
  always_comb begin
    case (trig_mode)
      TRG_A_ONLY:     trig = match_a;
      TRG_A_OR_B:     trig = match_a || match_b;
      TRG_A_THEN_B:   trig = st_q.a_seen && match_b;
      TRG_EVENT_B:    trig = match_b;
      TRG_A_THEN_EVB: trig = st_q.a_seen && match_b;
      TRG_A_AND_B:    trig = match_a && match_b;
      TRG_A_NOT_B:    trig = match_a && !match_b;
      TRG_INSIDE:     trig = st_q.valid && (st_q.addr >= cmp_a) && (st_q.addr <= cmp_b);
      TRG_OUTSIDE:    trig = st_q.valid && ((st_q.addr < cmp_a) || (st_q.addr > cmp_b));
      default:        trig = 1'b0;
    endcase
  end

  // ==========================================
  // run sequencer, fifo pointers and register port
  always_comb begin
    st_d        = st_q;
    mem_we      = 1'b0;
    mem_wa      = st_q.wp;
    mem_wd      = 16'h0000;
    done        = 1'b0;
    en_new      = 1'b0;
    arm_new     = 1'b0;
    st_d.brk    = 1'b0;
    st_d.frc    = 1'b0;
    st_d.valid  = bus_valid;
    st_d.fetch  = bus_valid && bus_fetch;
    st_d.addr   = bus_addr;
    st_d.data   = bus_data;
    // remember the newest opcode fetch for profiling
    if (st_q.fetch) begin
      st_d.last_fetch = st_q.addr;
    end
    if (armed) begin
      if (match_a) begin
        st_d.a_seen = 1'b1;
      end
      case (st_q.run)
        RUN_WAIT: begin
          if (trig) begin
            st_d.run = RUN_STORE;
          end
        end
        RUN_STORE: begin
          if (event_only ? trig : st_q.fetch) begin
            mem_we = 1'b1;
            // event-only keeps a data byte in the low half
            mem_wd = event_only ? {8'h00, st_q.data} : st_q.addr;
            st_d.wp = st_q.wp + 3'h1;
            if (st_q.cnt != FIFO_FULL) begin
              st_d.cnt = st_q.cnt + 4'h1;
            end
          end
          // begin trace ends full, end trace ends on trigger
          done = begin_eff ? (st_d.cnt == FIFO_FULL) : trig;
        end
        default: begin
          st_d.run = RUN_IDLE;
        end
      endcase
    end
    if (done) begin
      st_d.ctl[CTL_ARM] = 1'b0;
      st_d.run = RUN_IDLE;
      // oldest word first: a wrapped circular capture starts at the write pointer
      st_d.rp = (st_d.cnt == FIFO_FULL) ? st_d.wp : 3'h0;
      st_d.brk = st_q.ctl[CTL_BRK_EN];
      st_d.brk_tag = st_q.ctl[CTL_TAG];
    end
    // reads answer on the next cycle
    st_d.rdata = READ_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CMP_A_HIGH: st_d.rdata = st_q.cah;
        OFS_CMP_A_LOW:  st_d.rdata = st_q.cal;
        OFS_CMP_B_HIGH: st_d.rdata = st_q.cbh;
        OFS_CMP_B_LOW:  st_d.rdata = st_q.cbl;
        OFS_FIFO_HIGH:  st_d.rdata = event_only ? READ_ZERO : head[15:8];
        OFS_FIFO_LOW: begin
          st_d.rdata = head[7:0];
          // armed reads hold the pointer so capture is not disturbed
          if (!armed) begin
            mem_we = 1'b1;
            mem_wa = st_q.rp;
            mem_wd = st_q.last_fetch;
            st_d.rp = st_q.rp + 3'h1;
          end
        end
        OFS_CONTROL:    st_d.rdata = st_q.ctl;
        OFS_FORCE_RST:  st_d.rdata = READ_ZERO;
        default:        st_d.rdata = READ_ZERO;
      endcase
    end
    // writes come last so software wins over a run ending in the same cycle
    if (reg_wr) begin
      case (reg_addr)
        OFS_CMP_A_HIGH: if (!st_q.ctl[CTL_ARM]) st_d.cah = reg_wdata;
        OFS_CMP_A_LOW:  if (!st_q.ctl[CTL_ARM]) st_d.cal = reg_wdata;
        OFS_CMP_B_HIGH: if (!st_q.ctl[CTL_ARM]) st_d.cbh = reg_wdata;
        OFS_CMP_B_LOW:  if (!st_q.ctl[CTL_ARM]) st_d.cbl = reg_wdata;
        OFS_CONTROL: begin
          en_new  = reg_wdata[CTL_ENABLE] && !secure;
          arm_new = reg_wdata[CTL_ARM] && en_new;
          st_d.ctl = {en_new, arm_new, reg_wdata[5:0]};
          if (!arm_new) begin
            st_d.run = RUN_IDLE;
          end else if (!armed || done) begin
            // a fresh run clears pointers, count and sequence memory
            st_d.wp = 3'h0;
            st_d.rp = 3'h0;
            st_d.cnt = 4'h0;
            st_d.a_seen = 1'b0;
            st_d.run = begin_eff && !event_only ? RUN_WAIT : RUN_STORE;
          end
        end
        OFS_FORCE_RST: st_d.frc = reg_bdm && reg_wdata[FRC_BIT];
        default: st_d.frc = 1'b0;
      endcase
    end
  end

  // ==========================================
  // state register; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q       <= '0;
      st_q.ctl   <= CTL_RESET;
      st_q.cah   <= CMP_RESET;
      st_q.cal   <= CMP_RESET;
      st_q.cbh   <= CMP_RESET;
      st_q.cbl   <= CMP_RESET;
      st_q.run   <= RUN_IDLE;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign reg_rdata       = st_q.rdata;
  assign break_req       = st_q.brk;
  assign break_tag       = st_q.brk_tag;
  assign force_reset     = st_q.frc;
  assign run_active_flag = armed;
  assign fifo_count      = st_q.cnt;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_low_read_idle;
    ce && reg_rd && reg_addr == OFS_FIFO_LOW && !armed && !reg_wr;
  endsequence

  sequence s_pointer_stepped;
    st_q.rp == $past(st_q.rp) + 3'h1;
  endsequence

  chk_user_frc_ignored: assert property (
    ce && reg_wr && reg_addr == OFS_FORCE_RST && !reg_bdm |=> !force_reset)
    else $error("user write raised force reset");

  chk_frc_reads_zero: assert property (
    ce && reg_rd && reg_addr == OFS_FORCE_RST |=> reg_rdata == 8'h00)
    else $error("force reset register read nonzero");

  chk_host_frc_pulse: assert property (
    ce && reg_wr && reg_bdm && reg_addr == OFS_FORCE_RST && reg_wdata[0] |=> force_reset ##1 !force_reset)
    else $error("host force reset not a single pulse");

  chk_cmp_write_blocked: assert property (
    ce && reg_wr && reg_addr == OFS_CMP_A_HIGH && st_q.ctl[CTL_ARM] |=> $stable(st_q.cah))
    else $error("comparator changed while armed");

  chk_high_event_zero: assert property (
    ce && reg_rd && reg_addr == OFS_FIFO_HIGH && event_only |=> reg_rdata == 8'h00)
    else $error("fifo high nonzero in event-only mode");

  chk_high_no_advance: assert property (
    ce && reg_rd && reg_addr == OFS_FIFO_HIGH && !armed && !reg_wr |=> $stable(st_q.rp))
    else $error("fifo high read moved pointer");

  chk_low_advance: assert property (
    s_low_read_idle |=> s_pointer_stepped)
    else $error("disarmed fifo low read did not advance");

  chk_armed_hold: assert property (
    ce && reg_rd && reg_addr == OFS_FIFO_LOW && armed && !done && !reg_wr |=> $stable(st_q.rp))
    else $error("armed fifo low read moved pointer");

  chk_secure_enable: assert property (
    ce && secure && !st_q.ctl[CTL_ENABLE] |=> !st_q.ctl[CTL_ENABLE])
    else $error("enable set while secured");

  chk_break_gated: assert property (
    break_req |-> $past(st_q.ctl[CTL_BRK_EN]))
    else $error("break raised with break enable low");

  chk_arm_sets_flag: assert property (
    ce && reg_wr && reg_addr == OFS_CONTROL && reg_wdata[CTL_ENABLE] && reg_wdata[CTL_ARM] && !secure
    |=> run_active_flag)
    else $error("arm write did not raise run flag");

  chk_arm_clear_stops: assert property (
    ce && reg_wr && reg_addr == OFS_CONTROL && !(reg_wdata[CTL_ENABLE] && reg_wdata[CTL_ARM])
    |=> !run_active_flag)
    else $error("arm or enable clear did not stop the run");

  chk_ctl_write_lands: assert property (
    ce && reg_wr && reg_addr == OFS_CONTROL
    |=> st_q.ctl[CTL_TAG:CTL_B_DIREN] == $past(reg_wdata[CTL_TAG:CTL_B_DIREN]))
    else $error("control write lost");

  chk_cmp_write_open: assert property (
    ce && reg_wr && reg_addr == OFS_CMP_B_LOW && !st_q.ctl[CTL_ARM]
    |=> st_q.cbl == $past(reg_wdata))
    else $error("comparator write lost while disarmed");

  chk_full_ends_run: assert property (
    ce && armed && begin_eff && st_q.run == RUN_STORE && mem_we && st_q.cnt == FIFO_FULL - 4'h1 && !reg_wr
    |=> !run_active_flag && fifo_count == FIFO_FULL)
    else $error("begin trace did not end when full");

  chk_trigger_break: assert property (
    ce && armed && !begin_eff && st_q.run == RUN_STORE && trig && st_q.ctl[CTL_BRK_EN]
    |=> break_req && break_tag == $past(st_q.ctl[CTL_TAG]))
    else $error("end trace trigger gave no break of the chosen type");
endmodule : dct_top

// >>> verif/dct_bus_model.sv
// processor bus partner that issues the watched bus cycles
`timescale 1ns/1ps
module dct_bus_model (
  // clock
  input  wire logic        clk,
  // watched bus
  output logic             bus_valid,
  output logic             bus_rnw,
  output logic             bus_fetch,
  output logic [15:0]      bus_addr,
  output logic [7:0]       bus_data
);
  // ==========================================
  // idle bus
  // no valid cycle at start; lines parked away from any compare value
  initial begin
    bus_valid = 1'b0;
    bus_rnw   = 1'b1;
    bus_fetch = 1'b0;
    bus_addr  = 16'hffff;
    bus_data  = 8'hff;
  end
  // ==========================================
  // one bus cycle
  // launched after an edge, held through the sampling edge, then scrambled
  // so a stale address or byte can never pass for a fresh one
  task automatic cycle(input logic [15:0] a, input logic rnw, input logic fetch, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus_valid = 1'b1;
    bus_rnw   = rnw;
    bus_fetch = fetch;
    bus_addr  = a;
    bus_data  = d;
    @(posedge clk);
    #1;
    bus_valid = 1'b0;
    bus_fetch = 1'b0;
    bus_addr  = ~a;
    bus_data  = ~d;
  endtask : cycle
endmodule : dct_bus_model

// >>> verif/dct_top_bench.sv
// self-checking bench for the debug compare and trace registers
`timescale 1ns/1ps
module dct_top_bench;
  import dct_pkg::*;
  // ==========================================
  // signals
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        reg_bdm   = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        secure    = 1'b0;
  logic        ce        = 1'b1;
  logic [3:0]  trig_mode = 4'h0;
  logic [7:0]  reg_rdata;
  logic        bus_valid, bus_rnw, bus_fetch;
  logic [15:0] bus_addr;
  logic [7:0]  bus_data;
  logic        break_req, break_tag, force_reset, run_active_flag;
  logic [3:0]  fifo_count;
  int          n_fail    = 0;
  int          checks    = 0;
  // clock at 125 MHz
  always #4 clk = ~clk;
  // ==========================================
  // design and partner
  dct_top u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_bdm(reg_bdm), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .secure(secure), .trig_mode(trig_mode), .trig_begin(1'b0), .bus_valid(bus_valid),
    .bus_rnw(bus_rnw), .bus_fetch(bus_fetch), .bus_addr(bus_addr), .bus_data(bus_data),
    .break_req(break_req), .break_tag(break_tag), .force_reset(force_reset),
    .run_active_flag(run_active_flag), .fifo_count(fifo_count));
  dct_bus_model u_bus (.clk(clk), .bus_valid(bus_valid), .bus_rnw(bus_rnw),
    .bus_fetch(bus_fetch), .bus_addr(bus_addr), .bus_data(bus_data));
  // ==========================================
  // shared tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  // an idle edge before each access keeps strobes from being set twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic bdm = 1'b0);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_bdm   = bdm;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr  = 1'b0;
    reg_bdm = 1'b0;
  endtask : wr
  // read data is registered at the read edge and stands one cycle
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    check(reg_rdata, exp, what);
  endtask : rdc
  // watches a bounded span for a break pulse and the end of the run
  task automatic wait_break(input logic exp_brk, input logic exp_tag, input logic exp_run);
    logic seen = 1'b0;
    logic tg   = 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (break_req === 1'b1) begin
        seen = 1'b1;
        tg   = break_tag;
      end
    end
    check({7'h0, seen}, {7'h0, exp_brk}, "break request");
    if (exp_brk) check({7'h0, tg}, {7'h0, exp_tag}, "break type");
    check({7'h0, run_active_flag}, {7'h0, exp_run}, "run flag after bus cycle");
  endtask : wait_break
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [3:0] ofs [6] = '{OFS_CMP_A_HIGH, OFS_CMP_A_LOW, OFS_CMP_B_HIGH, OFS_CMP_B_LOW, OFS_CONTROL, OFS_FORCE_RST};
    foreach (ofs[i]) rdc(ofs[i], 8'h00, "reset value");
    // a write while the clock enable is low must leave no trace
    ce = 1'b0;
    wr(OFS_CMP_A_LOW, 8'h5a);
    ce = 1'b1;
    rdc(OFS_CMP_A_LOW, 8'h00, "write frozen by clock enable");
    $display("test reset done");
  endtask : t_reset
  task automatic t_force;
    wr(OFS_FORCE_RST, 8'h01);
    check({7'h0, force_reset}, 8'h00, "user force reset");
    rdc(OFS_FORCE_RST, 8'h00, "force reset read");
    wr(OFS_FORCE_RST, 8'h01, 1'b1);
    check({7'h0, force_reset}, 8'h01, "host force reset");
    @(posedge clk);
    #1;
    check({7'h0, force_reset}, 8'h00, "force reset pulse end");
    $display("test force reset done");
  endtask : t_force
  task automatic t_compare;
    wr(OFS_CMP_A_HIGH, 8'h12);
    wr(OFS_CMP_A_LOW, 8'h34);
    wr(OFS_CMP_B_HIGH, 8'h20);
    wr(OFS_CMP_B_LOW, 8'h00);
    rdc(OFS_CMP_A_LOW, 8'h34, "compare a low");
    wr(OFS_CONTROL, 8'hc0);
    check({7'h0, run_active_flag}, 8'h01, "armed flag");
    rdc(OFS_CONTROL, 8'hc0, "control while armed");
    rdc(OFS_FIFO_LOW, 8'h00, "armed low read");
    wr(OFS_CMP_A_HIGH, 8'h55);
    rdc(OFS_CMP_A_HIGH, 8'h12, "blocked compare write");
    wr(OFS_CONTROL, 8'h40);
    check({7'h0, run_active_flag}, 8'h00, "stop by enable low");
    secure = 1'b1;
    wr(OFS_CONTROL, 8'hc0);
    rdc(OFS_CONTROL, 8'h00, "enable while secured");
    secure = 1'b0;
    $display("test compare done");
  endtask : t_compare
  // one armed bus cycle per row: mode, control, address, direction, break expected
  task automatic t_trigger;
    logic [3:0]  md [11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0};
    logic [7:0]  ct [11] = '{8'hf0, 8'hd0, 8'hc0, 8'hdc, 8'hdc, 8'hd3, 8'hd3, 8'hd1, 8'hd1, 8'hd4, 8'hd4};
    logic [15:0] ad [11] = '{16'h1234, 16'h1234, 16'h1234, 16'h1234, 16'h1234, 16'h2000, 16'h2000,
                             16'h2000, 16'h2000, 16'h1234, 16'h1234};
    logic        rw [11] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic        ex [11] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 11; i++) begin
      trig_mode = md[i];
      wr(OFS_CONTROL, ct[i]);
      u_bus.cycle(ad[i], rw[i], 1'b0, 8'h00);
      if (ct[i] == 8'hc0) begin
        wait_break(1'b0, 1'b0, 1'b0);
        check({7'h0, run_active_flag}, 8'h00, "end trace run end");
      end
      else wait_break(ex[i], ct[i][CTL_TAG], ~ex[i]);
      wr(OFS_CONTROL, 8'h00);
    end
    $display("test trigger done");
  endtask : t_trigger
  task automatic t_event;
    trig_mode = TRG_EVENT_B;
    // break enable on: an event run is a begin trace, so filling must request a break
    wr(OFS_CONTROL, 8'hd0);
    for (int i = 0; i < 8; i++) u_bus.cycle(16'h2000, 1'b0, 1'b0, 8'h11 + 8'(i));
    wait_break(1'b1, 1'b0, 1'b0);
    check({7'h0, run_active_flag}, 8'h00, "run end when full");
    check({4'h0, fifo_count}, 8'h08, "word count");
    wr(OFS_FIFO_LOW, 8'hee);
    wr(OFS_FIFO_HIGH, 8'hee);
    rdc(OFS_FIFO_HIGH, 8'h00, "event high byte");
    for (int i = 0; i < 8; i++) rdc(OFS_FIFO_LOW, 8'h11 + 8'(i), "event byte");
    $display("test event done");
  endtask : t_event
  task automatic t_profile;
    trig_mode = TRG_A_ONLY;
    for (int i = 0; i < 8; i++) begin
      u_bus.cycle(16'ha0c0 + 16'(i), 1'b1, 1'b1, 8'h00);
      // the event reads refilled every slot with the fetch address then held, zero
      rdc(OFS_FIFO_LOW, 8'h00, "primed byte");
    end
    rdc(OFS_FIFO_HIGH, 8'ha0, "ninth read high");
    rdc(OFS_FIFO_HIGH, 8'ha0, "high read again");
    rdc(OFS_FIFO_LOW, 8'hc0, "ninth read low");
    rdc(OFS_FIFO_LOW, 8'hc1, "tenth read low");
    $display("test profile done");
  endtask : t_profile
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_force();
    t_compare();
    t_trigger();
    t_event();
    t_profile();
    final_report();
  end
  // the tests need a few hundred cycles; this span leaves ample margin
  initial begin
    #(20000 * 8);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule : dct_top_bench
